/* File: design/psp_pkg.sv */
// Constants, types and grouping decode for the power stage parallel block
`default_nettype none
package psp_pkg;
    // Stage indices into the eight-stage vectors
    localparam int PSP_LOW_1 = 0;
    localparam int PSP_LOW_2 = 1;
    localparam int PSP_LOW_3 = 2;
    localparam int PSP_LOW_4 = 3;
    localparam int PSP_HIGH_1 = 4;
    localparam int PSP_HIGH_2 = 5;
    localparam int PSP_HIGH_3 = 6;
    localparam int PSP_HIGH_4 = 7;
    localparam int PSP_STAGES = 8;

    // Serial command that loads the grouping register
    localparam logic [5:0] PSP_CONFIG_WRITE_CODE = 6'h33;
    localparam logic [7:0] PSP_GROUPING_RESET = 8'h00;

    // Latched fault codes
    localparam logic [1:0] PSP_FAULT_NONE = 2'h0;
    localparam logic [1:0] PSP_FAULT_OPEN = 2'h1;
    localparam logic [1:0] PSP_FAULT_SHORT = 2'h2;
    localparam logic [1:0] PSP_FAULT_OVC = 2'h3;

    // Timing, printed figures in ns, clock period 10 ns
    localparam longint PSP_CLK_PERIOD_NS = 10;
    localparam longint PSP_OVC_LOW_NS = 3000;
    localparam longint PSP_OVC_HIGH_NS = 4000;
    localparam longint PSP_OVC_PAR_NS = 8000;
    localparam longint PSP_OFF_FILTER_NS = 10000;
    localparam longint PSP_MASK_LOW_NS = 400000;
    localparam longint PSP_MASK_HIGH_NS = 1400000;
    localparam longint PSP_HOLD_NS = 600000000;
    localparam int PSP_OVC_LOW_CYC = int'(PSP_OVC_LOW_NS / PSP_CLK_PERIOD_NS);
    localparam int PSP_OVC_HIGH_CYC =
        int'(PSP_OVC_HIGH_NS / PSP_CLK_PERIOD_NS);
    localparam int PSP_OVC_PAR_CYC = int'(PSP_OVC_PAR_NS / PSP_CLK_PERIOD_NS);
    localparam int PSP_OFF_FILTER_CYC =
        int'(PSP_OFF_FILTER_NS / PSP_CLK_PERIOD_NS);
    localparam int PSP_MASK_LOW_CYC =
        int'(PSP_MASK_LOW_NS / PSP_CLK_PERIOD_NS);
    localparam int PSP_MASK_HIGH_CYC =
        int'(PSP_MASK_HIGH_NS / PSP_CLK_PERIOD_NS);
    localparam int PSP_HOLD_CYC = int'(PSP_HOLD_NS / PSP_CLK_PERIOD_NS);

    // Serial command from the host
    typedef struct packed {
        logic valid;
        logic [5:0] code;
        logic [7:0] data;
    } psp_cmd_type;

    // Analog sense of one stage
    typedef struct packed {
        logic ovc;
        logic [1:0] off_level;
    } psp_sense_type;

    // Active groups decoded from the grouping register
    typedef struct packed {
        logic low_12;
        logic low_34;
        logic low_234;
        logic low_all;
        logic high_12;
        logic high_34;
        logic high_234;
        logic high_all;
    } psp_groups_type;

    // Unlisted values leave every stage single
    function automatic psp_groups_type psp_decode(input logic [7:0] v);
        psp_groups_type g;
        g = '0;
        unique case (v)
            8'h02: g.low_12 = 1'b1;
            8'h04: begin
                g.low_12 = 1'b1;
                g.low_34 = 1'b1;
            end
            8'h08, 8'h48: g.low_all = 1'b1;
            8'h06: g.high_12 = 1'b1;
            8'h0e: begin
                g.high_12 = 1'b1;
                g.high_34 = 1'b1;
            end
            8'h0a, 8'h5a: g.high_all = 1'b1;
            8'h84: g.high_234 = 1'b1;
            8'h8c: g.low_234 = 1'b1;
            8'h12: begin
                g.low_12 = 1'b1;
                g.high_34 = 1'b1;
            end
            8'h14: begin
                g.low_12 = 1'b1;
                g.low_34 = 1'b1;
                g.high_34 = 1'b1;
            end
            8'hf4: begin
                g.low_234 = 1'b1;
                g.high_234 = 1'b1;
            end
            8'h36: begin
                g.low_34 = 1'b1;
                g.high_12 = 1'b1;
            end
            8'h74: g.low_12 = 1'b1;
            8'h2e: begin
                g.low_34 = 1'b1;
                g.high_12 = 1'b1;
                g.high_34 = 1'b1;
            end
            8'h56: begin
                g.low_all = 1'b1;
                g.high_12 = 1'b1;
            end
            8'h18: begin
                g.low_all = 1'b1;
                g.high_34 = 1'b1;
            end
            8'h42: begin
                g.low_12 = 1'b1;
                g.high_all = 1'b1;
            end
            8'h44: begin
                g.low_34 = 1'b1;
                g.high_all = 1'b1;
            end
            8'hb6: begin
                g.low_12 = 1'b1;
                g.high_12 = 1'b1;
            end
            default: g = '0;
        endcase
        return g;
    endfunction
endpackage
`default_nettype wire

/* File: design/psp_stage_timer.sv */
// One power stage: overcurrent trip, off-state mask and filter, fault latch
`default_nettype none
module psp_stage_timer #(
    parameter int OVC_SINGLE_CYC = 400,
    parameter int OVC_PAR_CYC = 800,
    parameter int MASK_CYC = 40000,
    parameter int OFF_FILTER_CYC = 1000
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Control
    input wire logic cmd_on_in,
    input wire logic cut_in,
    input wire logic paralleled_in,
    input wire logic diag_read_in,
    // Sense
    input wire psp_pkg::psp_sense_type sense_in,
    // Results
    output logic drive_out,
    output logic [1:0] fault_out
);
    import psp_pkg::*;

    localparam int CW = $clog2(MASK_CYC + OVC_PAR_CYC + OFF_FILTER_CYC + 2);

    if (OVC_SINGLE_CYC < 1 || OVC_PAR_CYC < 1 || MASK_CYC < 1 ||
        OFF_FILTER_CYC < 1) begin : g_bad
        $error("psp_stage_timer: counts must be at least one");
    end

    logic drive_q;
    logic trip_q;
    logic cmd_q;
    logic [CW-1:0] ovc_cnt_q;
    logic [CW-1:0] mask_cnt_q;
    logic [CW-1:0] off_cnt_q;
    logic [1:0] off_prev_q;
    logic [1:0] fault_q;
    logic [CW-1:0] ovc_limit;
    logic ovc_event;
    logic off_event;
    logic drive_d;

    // Grouped stages wait OVC_PAR_CYC instead of OVC_SINGLE_CYC before calling overcurrent
    assign ovc_limit = paralleled_in ? CW'(OVC_PAR_CYC - 1)
                                     : CW'(OVC_SINGLE_CYC - 1);
    // Each stage trips on its own comparator, never the group's
    assign ovc_event = drive_q && sense_in.ovc &&
                       ovc_cnt_q == ovc_limit;
    assign drive_d = cmd_on_in && !cut_in && !trip_q && !ovc_event;
    // Off diagnosis only once the mask has run out and the level held
    assign off_event = !drive_q && mask_cnt_q == '0 &&
                       sense_in.off_level != PSP_FAULT_NONE &&
                       sense_in.off_level == off_prev_q &&
                       off_cnt_q == CW'(OFF_FILTER_CYC - 1);

    // Output stage register
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            drive_q <= 1'b0;
            cmd_q <= 1'b0;
        end else begin
            drive_q <= drive_d;
            cmd_q <= cmd_on_in;
        end
    end

    // Overcurrent persistence counter
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            ovc_cnt_q <= '0;
        end else if (drive_q && sense_in.ovc && ovc_cnt_q != ovc_limit) begin
            ovc_cnt_q <= ovc_cnt_q + CW'(1);
        end else begin
            ovc_cnt_q <= '0;
        end
    end

    // Trip holds the stage off; release on re-command or diagnosis read
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            trip_q <= 1'b0;
        end else if (ovc_event) begin
            trip_q <= 1'b1;
        end else if (!cmd_on_in || (diag_read_in && cmd_q)) begin
            trip_q <= 1'b0;
        end
    end

    // Mask window restarts on every switch-off
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            mask_cnt_q <= '0;
        end else if (drive_q && !drive_d) begin
            mask_cnt_q <= CW'(MASK_CYC - 1);
        end else if (drive_q) begin
            mask_cnt_q <= '0;
        end else if (mask_cnt_q != '0) begin
            mask_cnt_q <= mask_cnt_q - CW'(1);
        end
    end

    // Off-state level must stay the same for the filter time
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            off_cnt_q <= '0;
            off_prev_q <= PSP_FAULT_NONE;
        end else begin
            off_prev_q <= sense_in.off_level;
            if (drive_q || mask_cnt_q != '0 ||
                sense_in.off_level == PSP_FAULT_NONE ||
                sense_in.off_level != off_prev_q) begin
                off_cnt_q <= '0;
            end else if (off_cnt_q != CW'(OFF_FILTER_CYC - 1)) begin
                off_cnt_q <= off_cnt_q + CW'(1);
            end
        end
    end

    // Fault latch: on fault overrides, first off fault sticks, set beats read
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            fault_q <= PSP_FAULT_NONE;
        end else if (ovc_event) begin
            fault_q <= PSP_FAULT_OVC;
        end else if (off_event && (fault_q == PSP_FAULT_NONE ||
                                   diag_read_in)) begin
            fault_q <= sense_in.off_level;
        end else if (diag_read_in) begin
            fault_q <= PSP_FAULT_NONE;
        end
    end

    assign drive_out = drive_q;
    assign fault_out = fault_q;
endmodule
`default_nettype wire

/* File: design/psp_stage_ctrl.sv */
// Grouping register, stage routing, low battery hold and fault reporting
`default_nettype none
// How it works
// - Low pairs 1+2 and 3+4 may be paralleled
// - Config write command 110011 loads grouping register
// - Ungrouped stages run as independent singles
// - Low pairs: enable/diag per pair stage table
// - High pairs: H2 enables 1+2, H3 drives 3+4
// - High triple 2-3-4: enable H2, diag H3
// - Low triple 2-3-4: enable and diag on L2
// - Low quad: enable L2, diagnosis on L1
// - Low and high groups may combine, only in the listed table values
// - Grouped stages use an 8 us overcurrent filter (single: low 3 us, high 4 us)
// - Thresholds stay per stage whatever grouping
// - Low-side off diagnosis masked 400 us
// - Low-side off faults filtered 10 us
// - High-side off diagnosis masked 1.2-1.6 ms
// - High-side overcurrent filter about 4 us
// - Low battery: H1, H3 held on, then off
// - Diagnosis read clears latched fault codes
module psp_stage_ctrl #(
    parameter int MASK_LOW_CYC = psp_pkg::PSP_MASK_LOW_CYC,
    parameter int MASK_HIGH_CYC = psp_pkg::PSP_MASK_HIGH_CYC,
    parameter int HOLD_CYC = psp_pkg::PSP_HOLD_CYC
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Serial command and diagnosis read
    input wire psp_pkg::psp_cmd_type cmd_in,
    input wire logic diag_read_in,
    // Stage commands and sense
    input wire logic [7:0] stage_cmd_in,
    input wire psp_pkg::psp_sense_type [7:0] stage_sense_in,
    input wire logic low_batt_in,
    // Results
    output logic [7:0] stage_drive_out,
    output logic [15:0] stage_fault_out,
    output logic [7:0] grouping_out,
    output logic [7:0] paralleled_out
);
    import psp_pkg::*;

    if (MASK_LOW_CYC < 1 || MASK_HIGH_CYC < 1 || HOLD_CYC < 1) begin : g_bad
        $error("psp_stage_ctrl: counts must be at least one");
    end

    logic [7:0] grouping_q;
    psp_groups_type groups;
    logic [2:0] src_idx [PSP_STAGES];
    logic [2:0] diag_idx [PSP_STAGES];
    logic [7:0] member;
    logic [7:0] eff_cmd;
    logic [7:0] cut;
    logic [7:0] drive;
    logic [1:0] fault [PSP_STAGES];
    logic [15:0] fault_d;
    logic [31:0] hold_cnt_q;
    logic batt_cut_q;

    // Grouping register, write-only from the serial link
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            grouping_q <= PSP_GROUPING_RESET;
        end else if (cmd_in.valid &&
                     cmd_in.code == PSP_CONFIG_WRITE_CODE) begin
            grouping_q <= cmd_in.data;
        end
    end

    // Table lookup; values not listed fall back to all single
    assign groups = psp_decode(grouping_q);

    // Who commands and who reports each stage
    always_comb begin
        for (int i = 0; i < PSP_STAGES; i++) begin
            src_idx[i] = 3'(i);
            diag_idx[i] = 3'(i);
        end
        member = 8'h00;
        if (groups.low_12) begin
            src_idx[PSP_LOW_1] = 3'(PSP_LOW_2);
            src_idx[PSP_LOW_2] = 3'(PSP_LOW_2);
            diag_idx[PSP_LOW_1] = 3'(PSP_LOW_1);
            diag_idx[PSP_LOW_2] = 3'(PSP_LOW_1);
            member[PSP_LOW_1] = 1'b1;
            member[PSP_LOW_2] = 1'b1;
        end
        if (groups.low_34) begin
            src_idx[PSP_LOW_4] = 3'(PSP_LOW_3);
            diag_idx[PSP_LOW_4] = 3'(PSP_LOW_3);
            member[PSP_LOW_3] = 1'b1;
            member[PSP_LOW_4] = 1'b1;
        end
        if (groups.low_234) begin
            src_idx[PSP_LOW_3] = 3'(PSP_LOW_2);
            src_idx[PSP_LOW_4] = 3'(PSP_LOW_2);
            diag_idx[PSP_LOW_3] = 3'(PSP_LOW_2);
            diag_idx[PSP_LOW_4] = 3'(PSP_LOW_2);
            member[PSP_LOW_4:PSP_LOW_2] = 3'h7;
        end
        if (groups.low_all) begin
            for (int i = PSP_LOW_1; i <= PSP_LOW_4; i++) begin
                src_idx[i] = 3'(PSP_LOW_2);
                diag_idx[i] = 3'(PSP_LOW_1);
            end
            member[PSP_LOW_4:PSP_LOW_1] = 4'hf;
        end
        if (groups.high_12) begin
            src_idx[PSP_HIGH_1] = 3'(PSP_HIGH_2);
            diag_idx[PSP_HIGH_2] = 3'(PSP_HIGH_1);
            member[PSP_HIGH_1] = 1'b1;
            member[PSP_HIGH_2] = 1'b1;
        end
        if (groups.high_34) begin
            src_idx[PSP_HIGH_4] = 3'(PSP_HIGH_3);
            diag_idx[PSP_HIGH_4] = 3'(PSP_HIGH_3);
            member[PSP_HIGH_3] = 1'b1;
            member[PSP_HIGH_4] = 1'b1;
        end
        if (groups.high_234) begin
            src_idx[PSP_HIGH_3] = 3'(PSP_HIGH_2);
            src_idx[PSP_HIGH_4] = 3'(PSP_HIGH_2);
            diag_idx[PSP_HIGH_2] = 3'(PSP_HIGH_3);
            diag_idx[PSP_HIGH_4] = 3'(PSP_HIGH_3);
            member[PSP_HIGH_4:PSP_HIGH_2] = 3'h7;
        end
        if (groups.high_all) begin
            for (int i = PSP_HIGH_1; i <= PSP_HIGH_4; i++) begin
                src_idx[i] = 3'(PSP_HIGH_2);
                diag_idx[i] = 3'(PSP_HIGH_1);
            end
            member[PSP_HIGH_4:PSP_HIGH_1] = 4'hf;
        end
    end

    // Low battery hold timer; restarts whenever battery recovers
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            hold_cnt_q <= '0;
            batt_cut_q <= 1'b0;
        end else if (!low_batt_in) begin
            hold_cnt_q <= '0;
            batt_cut_q <= 1'b0;
        end else if (!batt_cut_q) begin
            if (hold_cnt_q == 32'(HOLD_CYC - 1)) begin
                batt_cut_q <= 1'b1;
            end else begin
                hold_cnt_q <= hold_cnt_q + 32'h1;
            end
        end
    end

    // Per-stage routing and timers
    for (genvar i = 0; i < PSP_STAGES; i++) begin : g_stage
        localparam bit IS_LOW = i <= PSP_LOW_4;
        assign eff_cmd[i] = stage_cmd_in[src_idx[i]];
        // Only the two held high stages see the battery cut
        assign cut[i] = batt_cut_q &&
                        (i == PSP_HIGH_1 || i == PSP_HIGH_3);
        psp_stage_timer #(
            .OVC_SINGLE_CYC(IS_LOW ? PSP_OVC_LOW_CYC : PSP_OVC_HIGH_CYC),
            .OVC_PAR_CYC(PSP_OVC_PAR_CYC),
            .MASK_CYC(IS_LOW ? MASK_LOW_CYC : MASK_HIGH_CYC),
            .OFF_FILTER_CYC(PSP_OFF_FILTER_CYC)
        ) u_timer (
            .sys_clk_in(sys_clk_in),
            .reset_n_in(reset_n_in),
            .cmd_on_in(eff_cmd[i]),
            .cut_in(cut[i]),
            .paralleled_in(member[i]),
            .diag_read_in(diag_read_in),
            .sense_in(stage_sense_in[i]),
            .drive_out(drive[i]),
            .fault_out(fault[i])
        );
    end

    // Group faults gather on the reporting stage, others read clean
    always_comb begin
        fault_d = '0;
        for (int i = 0; i < PSP_STAGES; i++) begin
            for (int j = 0; j < PSP_STAGES; j++) begin
                if (diag_idx[j] == 3'(i)) begin
                    fault_d[2*i +: 2] = fault_d[2*i +: 2] | fault[j];
                end
            end
        end
    end

    // Registered fault report
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            stage_fault_out <= '0;
        end else begin
            stage_fault_out <= fault_d;
        end
    end

    assign stage_drive_out = drive;
    assign grouping_out = grouping_q;
    assign paralleled_out = member;
endmodule
`default_nettype wire

/* File: bench/psp_checker_properties.sv */
// Checker for grouping load and stage routing at the controller ports
`default_nettype none
module psp_checker
    import psp_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Watched ports
    input wire psp_pkg::psp_cmd_type cmd_in,
    input wire logic [7:0] stage_cmd_in,
    input wire logic [7:0] stage_drive_out,
    input wire logic [15:0] stage_fault_out,
    input wire logic [7:0] grouping_out,
    input wire logic [7:0] paralleled_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    // Reset leaves all stages single, off and fault free
    property p_reset;
        $rose(reset_n_in) |-> grouping_out == 8'h00 &&
            stage_drive_out == 8'h00 && stage_fault_out == 16'h0000;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not clear after reset");
    property p_load;
        cmd_in.valid && cmd_in.code == 6'h33 |=>
            grouping_out == $past(cmd_in.data);
    endproperty
    a_load: assert property (p_load)
        else $error("grouping write not loaded");
    // Other codes must not disturb the grouping
    property p_ignore;
        cmd_in.valid && cmd_in.code != 6'h33 |=> $stable(grouping_out);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("grouping changed by other code");
    // Off commands only, so a trip can never make these fire
    property p_single;
        grouping_out == 8'h00 && !stage_cmd_in[0] |->
            paralleled_out == 8'h00 ##1 !stage_drive_out[0];
    endproperty
    a_single: assert property (p_single)
        else $error("single stage not following own command");
    property p_low_pair;
        grouping_out == 8'h02 && !stage_cmd_in[1] |->
            paralleled_out == 8'h03 ##1 stage_drive_out[1:0] == 2'b00;
    endproperty
    a_low_pair: assert property (p_low_pair)
        else $error("low pair not following its source");
    property p_high_pair;
        grouping_out == 8'h06 && !stage_cmd_in[5] |->
            paralleled_out == 8'h30 ##1 stage_drive_out[5:4] == 2'b00;
    endproperty
    a_high_pair: assert property (p_high_pair)
        else $error("high pair not following its source");
    property p_low_quad;
        grouping_out == 8'h08 && !stage_cmd_in[1] |->
            paralleled_out == 8'h0f ##1 stage_drive_out[3:0] == 4'h0;
    endproperty
    a_low_quad: assert property (p_low_quad)
        else $error("low quad not following its source");
    property p_mixed;
        grouping_out == 8'h14 && stage_cmd_in[6] == 1'b0 &&
            stage_cmd_in[2:1] == 2'b00 |->
            paralleled_out == 8'hcf ##1 (stage_drive_out & 8'hcf) == 8'h00;
    endproperty
    a_mixed: assert property (p_mixed)
        else $error("combined groups not following sources");
endmodule
bind psp_stage_ctrl psp_checker i_chk (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .cmd_in(cmd_in), .stage_cmd_in(stage_cmd_in),
    .stage_drive_out(stage_drive_out), .stage_fault_out(stage_fault_out),
    .grouping_out(grouping_out), .paralleled_out(paralleled_out));
`default_nettype wire

/* File: bench/psp_host_model.sv */
// Host model: grouping writes and diagnosis reads on the command link
`default_nettype none
module psp_host_model
    import psp_pkg::*;
(
    // Clock
    input wire logic sys_clk_in,
    // Command link
    output var psp_pkg::psp_cmd_type cmd_out,
    output var logic diag_read_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle link at time zero
    initial begin
        cmd_out = '0;
        diag_read_out = 1'b0;
    end
    // Word valid one cycle; idle word inverted so stale data never matches
    task automatic send(input logic [5:0] code, input logic [7:0] data);
        @(negedge sys_clk_in);
        cmd_out = {1'b1, code, data};
        @(negedge sys_clk_in);
        cmd_out = {1'b0, ~code, ~data};
    endtask
    task automatic write_config(input logic [7:0] data);
        send(6'h33, data);
    endtask
    // Diagnosis read pulse of one cycle
    task automatic diag_read();
        @(negedge sys_clk_in);
        diag_read_out = 1'b1;
        @(negedge sys_clk_in);
        diag_read_out = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: bench/tb_power_stage_parallel_config.sv */
// Bench: grouping, routing, fault timing and low battery hold
`default_nettype none
module tb_power_stage_parallel_config;
    timeunit 1ns;
    timeprecision 1ps;
    import psp_pkg::*;
    localparam int MASK_LOW = 20;
    localparam int MASK_HIGH = 30;
    localparam int HOLD = 50;
    // Value in upper byte, group flags below, from bit 0: low12 low34
    // low234 lowall high12 high34 high234 highall
    localparam logic [15:0] GROUPS [23] = '{16'h0000, 16'h0201, 16'h0403,
        16'h0808, 16'h4808, 16'h0610, 16'h0e30, 16'h0a80, 16'h5a80,
        16'h8440, 16'h8c04, 16'h1221, 16'h1423, 16'hf444, 16'h3612,
        16'h7401, 16'h2e32, 16'h5618, 16'h1828, 16'h4281, 16'h4482,
        16'hb611, 16'hff00};
    logic sys_clk_in, reset_n_in, diag_read_in, low_batt_in;
    psp_cmd_type cmd_in;
    logic [7:0] stage_cmd_in, stage_drive_out, grouping_out, paralleled_out;
    psp_sense_type [7:0] stage_sense_in;
    logic [15:0] stage_fault_out;
    logic [31:0] lfsr = 32'hb77086c8;
    int bad_count = 0;
    int compares = 0;
    // Free running clock
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // Short mask and hold counts keep the run brief
    psp_stage_ctrl #(.MASK_LOW_CYC(MASK_LOW), .MASK_HIGH_CYC(MASK_HIGH),
        .HOLD_CYC(HOLD)) i_dut (.sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in), .cmd_in(cmd_in),
        .diag_read_in(diag_read_in), .stage_cmd_in(stage_cmd_in),
        .stage_sense_in(stage_sense_in), .low_batt_in(low_batt_in),
        .stage_drive_out(stage_drive_out), .stage_fault_out(stage_fault_out),
        .grouping_out(grouping_out), .paralleled_out(paralleled_out));
    psp_host_model i_host (.sys_clk_in(sys_clk_in), .cmd_out(cmd_in),
        .diag_read_out(diag_read_in));
    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // Stage whose command a stage follows under the given flags
    function automatic int src_of(input logic [7:0] f, input int s);
        int r;
        r = s;
        if (f[0] && s < 2) r = 1;
        if (f[1] && s inside {2, 3}) r = 2;
        if (f[2] && s inside {[1:3]}) r = 1;
        if (f[3] && s < 4) r = 1;
        if (f[4] && s inside {4, 5}) r = 5;
        if (f[5] && s > 5) r = 6;
        if (f[6] && s > 4) r = 5;
        if (f[7] && s > 3) r = 5;
        return r;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic timeout(input string what);
        bad_count++;
        $display("Error %s expected done seen timeout", what);
        end_of_test();
    endtask
    task automatic check8(input string what, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check16(input string what, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_range(input string what, input int lo, hi, g);
        compares++;
        if (g < lo || g > hi) begin
            bad_count++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, g);
        end
    endtask
    // Every grouping value, random commands, model routing each cycle
    task automatic test_grouping();
        logic [7:0] f, e, p;
        foreach (GROUPS[k]) begin
            i_host.write_config(GROUPS[k][15:8]);
            f = GROUPS[k][7:0];
            p = 8'h00;
            for (int s = 0; s < 8; s++) begin
                if (src_of(f, s) != s) p |= 8'(1 << s) | 8'(1 << src_of(f, s));
            end
            check8("grouping", GROUPS[k][15:8], grouping_out);
            check8("paralleled", p, paralleled_out);
            for (int n = 0; n < 12; n++) begin
                stage_cmd_in = 8'(next_rand());
                tick(1);
                for (int s = 0; s < 8; s++) e[s] = stage_cmd_in[src_of(f, s)];
                check8("drive", e, stage_drive_out);
            end
        end
        i_host.send(6'h32, 8'h02);
        check8("refused write", 8'hff, grouping_out);
        $display("grouping sweep done");
    endtask
    // Trip (n = filter) or off fault (n = mask) on st, reported on dg
    task automatic test_fault(input logic [7:0] grp, input int st, src, dg,
        input int n, input logic [1:0] code);
        int cnt;
        i_host.write_config(grp);
        stage_cmd_in = 8'h00;
        stage_cmd_in[src] = 1'b1;
        tick(3);
        cnt = 0;
        if (code == PSP_FAULT_OVC) begin
            stage_sense_in[st].ovc = 1'b1;
            while (stage_drive_out[st] === 1'b1) begin
                tick(1);
                cnt++;
                if (cnt > 2000) timeout("trip");
            end
            check_range("trip cycles", n, n + 1, cnt);
            stage_sense_in[st].ovc = 1'b0;
            tick(3);
        end else begin
            stage_cmd_in[src] = 1'b0;
            stage_sense_in[st].off_level = code;
            tick(n + 995);
            check16("masked fault", 16'h0000, stage_fault_out);
            while (stage_fault_out === 16'h0000) begin
                tick(1);
                cnt++;
                if (cnt > 20) timeout("off fault");
            end
            stage_sense_in[st].off_level = 2'h0;
        end
        check16("fault", 16'(code) << (2 * dg), stage_fault_out);
        i_host.diag_read();
        tick(2);
        check16("cleared", 16'h0000, stage_fault_out);
        check8("restart", {7'h00, code == PSP_FAULT_OVC},
            {7'h00, stage_drive_out[st]});
        stage_cmd_in = 8'h00;
        tick(2);
        $display("fault test on stage %0d done", st);
    endtask
    // Low battery: stages high 1 and 3 hold, then drop, others stay on
    task automatic test_battery();
        int cnt;
        stage_cmd_in = 8'hff;
        tick(2);
        low_batt_in = 1'b1;
        tick(HOLD - 2);
        check8("held", 8'hff, stage_drive_out);
        cnt = 0;
        while (stage_drive_out[4] === 1'b1) begin
            tick(1);
            cnt++;
            if (cnt > 10) timeout("battery cut");
        end
        check_range("hold cycles", HOLD, HOLD + 1, HOLD - 2 + cnt);
        check8("cut", 8'haf, stage_drive_out);
        low_batt_in = 1'b0;
        tick(3);
        check8("released", 8'hff, stage_drive_out);
        $display("battery hold done");
    endtask
    // Main sequence, inputs changed at falling edges
    initial begin
        reset_n_in = 1'b0;
        low_batt_in = 1'b0;
        stage_cmd_in = 8'h00;
        stage_sense_in = '0;
        tick(2);
        reset_n_in = 1'b1;
        tick(1);
        check8("reset grouping", 8'h00, grouping_out);
        check8("reset drive", 8'h00, stage_drive_out);
        test_grouping();
        reset_n_in = 1'b0;
        tick(1);
        reset_n_in = 1'b1;
        tick(1);
        check8("reset grouping", 8'h00, grouping_out);
        test_fault(8'h00, 0, 0, 0, 300, PSP_FAULT_OVC);
        test_fault(8'h00, 4, 4, 4, 400, PSP_FAULT_OVC);
        test_fault(8'h02, 1, 1, 0, 800, PSP_FAULT_OVC);
        test_fault(8'h06, 5, 5, 4, 800, PSP_FAULT_OVC);
        test_fault(8'h02, 1, 1, 0, MASK_LOW, PSP_FAULT_OPEN);
        test_fault(8'h00, 4, 4, 4, MASK_HIGH, PSP_FAULT_SHORT);
        test_battery();
        end_of_test();
    end
endmodule
`default_nettype wire
